// ---- shared/ucca_pkg.sv ----
// constants and types shared by the serial command interpreter
// assumes one 125 MHz clock and a synchronous active-high reset
//
// How it works
// - top two command bits pick the operation
// - low six bits address RAM 0-63, store 0-47
// - store read at address 63 requests reset
// - read command returns addressed byte unprompted
// - write command is echoed before data
// - stored write answered by two BCh bytes
// - alarm uses five bytes in fixed order
// - levels compare upper 8 of 10 bits
// - alarm source from byte 31 upper nibble
// - below low or above high forces alarm level
// - steering enabled disables the alarm
// - steering drives aux pins as two-bit code
// - steering source only four permitted codes
// - bit 7 checksum test, failure forces fault value
// - bit 5 alarm, bit 4 steering, else inputs
// - bits 3..0 fast clock, voltage, ext sensor, current
// - both outputs in digital mode fix current value
// - frame is start, eight data, stop
// - reset request sends BCh then resets
// - stored changes act only after reset
`default_nettype none
package ucca_pkg;
  localparam int unsigned CLK_HZ = 125000000; // system clock
  localparam int unsigned BAUD = 2500000; // link rate, plain default
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD; // cycles per bit
  localparam int unsigned BIT_CYC_W = 14; // bit counter width
  localparam logic [1:0] OP_RAM_RD = 2'h3; // read RAM byte
  localparam logic [1:0] OP_NV_RD = 2'h2; // read store byte
  localparam logic [1:0] OP_NV_WR = 2'h1; // write store byte
  localparam logic [1:0] OP_RAM_WR = 2'h0; // write RAM byte
  localparam logic [5:0] NV_LAST = 6'h2f; // highest store address
  localparam logic [5:0] RESET_ADDR = 6'h3f; // reset request address
  localparam logic [7:0] ACK_BYTE = 8'hbc; // acknowledge value
  localparam logic [5:0] MODE_ADDR = 6'h00; // operating_mode_byte
  localparam logic [5:0] ALM_LO_TRIG = 6'h1b; // low trigger limit
  localparam logic [5:0] ALM_LO_OUT = 6'h1c; // low output level
  localparam logic [5:0] ALM_HI_TRIG = 6'h1d; // high trigger limit
  localparam logic [5:0] ALM_HI_OUT = 6'h1e; // high output level
  localparam logic [5:0] ALM_CTRL = 6'h1f; // alarm_source_control
  localparam logic [5:0] STEER_CTRL = 6'h1f; // shared control byte
  localparam logic [5:0] STEER_L1 = 6'h1c; // first transition
  localparam logic [5:0] STEER_L2 = 6'h1d; // second transition
  localparam logic [5:0] STEER_L3 = 6'h1e; // third transition
  localparam logic [5:0] FAULT_HI = 6'h28; // fault value high
  localparam logic [5:0] FAULT_LO = 6'h29; // fault value low
  localparam logic [5:0] FIXCUR_HI = 6'h2a; // fixed current high
  localparam logic [5:0] FIXCUR_LO = 6'h2b; // fixed current low
  localparam logic [7:0] CSUM_GOOD = 8'hff; // expected byte sum
  localparam int unsigned MB_CSUM = 7; // checksum enable bit
  localparam int unsigned MB_DIG = 6; // digital mode bit
  localparam int unsigned MB_ALARM = 5; // alarm enable bit
  localparam int unsigned MB_STEER = 4; // steering enable bit
  localparam int unsigned MB_FAST = 3; // fast clock bit
  localparam int unsigned MB_VOUT = 2; // voltage output bit
  localparam int unsigned MB_EXTT = 1; // external sensor bit
  localparam int unsigned MB_IOUT = 0; // current output bit
  localparam logic [3:0] SRC_TEMP = 4'h2; // temp_amp_output
  localparam logic [3:0] SRC_INSTR = 4'h6; // instr_amp_output
  localparam logic [3:0] SRC_GAIN = 4'h0; // gain_stage_output
  localparam logic [3:0] SRC_VOUT = 4'h3; // voltage_output_mode
  localparam logic [3:0] SRC_AUXA = 4'h4; // aux_pin_a
  localparam logic [3:0] SRC_AUXB = 4'h5; // aux_pin_b
  typedef enum logic [3:0] {
    UCCA_IDLE = 4'b0000,
    UCCA_RDMEM = 4'b0001,
    UCCA_SEND_RD = 4'b0010,
    UCCA_SEND_ECHO = 4'b0011,
    UCCA_WAIT_DATA = 4'b0100,
    UCCA_STORE = 4'b0101,
    UCCA_SEND_ACK1 = 4'b0110,
    UCCA_SEND_ACK2 = 4'b0111,
    UCCA_SEND_RST = 4'b1000,
    UCCA_TX_WAIT = 4'b1001,
    UCCA_BOOT = 4'b1010
  } ucca_state_t;
endpackage : ucca_pkg
`default_nettype wire

// ---- hdl/ucca_mem.sv ----
// one 64-byte memory with a registered read port
// assumes single clock, synchronous writes
`default_nettype none
module ucca_mem (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [5:0] raddr,
  output logic [7:0] rdata
);
  // storage array
  logic [7:0] mem [0:63];

  // write then registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : ucca_mem
`default_nettype wire

// ---- hdl/ucca_top.sv ----
// serial command interpreter with alarm and level steering
// assumes host on an 8N1 link at the package bit rate; signal
// inputs are asynchronous and pass two flip-flops before use
`default_nettype none
module ucca_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic rx_pin,
  output logic tx_pin,
  // digitized signal sources, 10 bits each
  input wire logic [9:0] temp_amp_output,
  input wire logic [9:0] instr_amp_output,
  input wire logic [9:0] gain_stage_output,
  input wire logic [9:0] voltage_output_mode,
  input wire logic [9:0] aux_pin_a_level,
  input wire logic [9:0] aux_pin_b_level,
  // aux pins as two-bit steering code
  output logic aux_pin_a_o,
  output logic aux_pin_a_oe,
  output logic aux_pin_b_o,
  output logic aux_pin_b_oe,
  // output supervision
  output logic digital_output_override,
  output logic [9:0] override_value,
  output logic [9:0] current_fixed_value,
  output logic current_fixed,
  // mode byte and soft reset pulse
  output logic [7:0] operating_mode_byte,
  output logic soft_reset_pulse
);
  import ucca_pkg::*;

  // synchronizers
  logic rx_s1_r, rx_s2_r; // serial line
  logic [9:0] src_s1_r [0:5]; // sources stage one
  logic [9:0] src_s2_r [0:5]; // sources stage two
  always_ff @(posedge clk) begin
    rx_s1_r <= rx_pin;
    rx_s2_r <= rx_s1_r;
    src_s1_r[0] <= temp_amp_output;
    src_s1_r[1] <= instr_amp_output;
    src_s1_r[2] <= gain_stage_output;
    src_s1_r[3] <= voltage_output_mode;
    src_s1_r[4] <= aux_pin_a_level;
    src_s1_r[5] <= aux_pin_b_level;
    src_s2_r <= src_s1_r;
  end

  // receiver: start low, 8 data, stop high
  logic [BIT_CYC_W-1:0] rx_cnt_r; // bit timer
  logic [3:0] rx_bit_r; // bit index
  logic [7:0] rx_sh_r; // shift register
  logic rx_busy_r; // frame in progress
  logic rx_vld_r; // one-cycle byte strobe
  always_ff @(posedge clk) begin
    rx_vld_r <= 1'b0;
    if (rst) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
    end else if (!rx_busy_r) begin
      if (!rx_s2_r) begin // start edge
        rx_busy_r <= 1'b1;
        rx_cnt_r <= BIT_CYC_W'(BIT_CYC / 2);
        rx_bit_r <= '0;
      end
    end else if (rx_cnt_r != '0) begin
      rx_cnt_r <= rx_cnt_r - 1'b1;
    end else begin
      rx_cnt_r <= BIT_CYC_W'(BIT_CYC - 1);
      rx_bit_r <= rx_bit_r + 1'b1;
      if (rx_bit_r == 4'h0) begin
        if (rx_s2_r) begin // false start
          rx_busy_r <= 1'b0;
        end
      end else if (rx_bit_r == 4'h9) begin
        rx_busy_r <= 1'b0;
        rx_vld_r <= rx_s2_r; // drop bad stop
      end else begin
        rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]}; // lsb first
      end
    end
  end

  // transmitter
  logic tx_go; // start a byte
  logic [7:0] tx_byte; // byte to send
  logic [9:0] tx_sh_r; // frame shift register
  logic [BIT_CYC_W-1:0] tx_cnt_r; // bit timer
  logic [3:0] tx_left_r; // bits remaining
  wire tx_busy = (tx_left_r != 4'h0) || (tx_cnt_r != '0); // whole stop
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_pin <= 1'b1;
      tx_sh_r <= '1;
      tx_cnt_r <= '0;
      tx_left_r <= '0;
    end else if (tx_go && !tx_busy) begin
      tx_sh_r <= {1'b1, tx_byte, 1'b0};
      tx_left_r <= 4'ha;
      tx_cnt_r <= '0;
    end else if (tx_busy) begin
      if (tx_cnt_r == '0) begin
        tx_pin <= tx_sh_r[0];
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        tx_cnt_r <= BIT_CYC_W'(BIT_CYC - 1);
        tx_left_r <= tx_left_r - 1'b1;
      end else begin
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end
    end
  end

  // command sequencer
  ucca_state_t st_r, st_nxt; // state
  ucca_state_t ret_r; // state after tx completes
  logic [7:0] cmd_r; // command byte
  logic [7:0] boot_sum_r; // checksum accumulator
  logic [6:0] boot_idx_r; // boot walk index
  logic csum_fail_r; // checksum failed
  logic ram_we, nv_we; // write strobes
  logic [5:0] ram_ra, nv_ra; // read addresses
  logic [7:0] ram_rd, nv_rd; // read data
  wire [1:0] op = cmd_r[7:6];
  wire [5:0] addr = cmd_r[5:0];

  ucca_mem u_ram (
    .clk(clk), .we(ram_we), .waddr(addr), .wdata(rx_sh_r),
    .raddr(ram_ra), .rdata(ram_rd)
  );
  ucca_mem u_nv (
    .clk(clk), .we(nv_we), .waddr(addr), .wdata(rx_sh_r),
    .raddr(nv_ra), .rdata(nv_rd)
  );

  // active config shadow, loaded only at boot
  logic [7:0] cfg_r [0:47];
  logic boot_rd_ok_r; // read data valid during boot
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_rd_ok_r <= 1'b0;
    end else begin
      boot_rd_ok_r <= (st_r == UCCA_BOOT) && (boot_idx_r <= 7'd47);
    end
  end
  always_ff @(posedge clk) begin
    if (boot_rd_ok_r) begin
      cfg_r[6'(boot_idx_r - 7'd1)] <= nv_rd;
    end
  end

  // next state and strobes
  always_comb begin
    st_nxt = st_r;
    tx_go = 1'b0;
    tx_byte = ACK_BYTE;
    ram_we = 1'b0;
    nv_we = 1'b0;
    ram_ra = addr;
    nv_ra = (st_r == UCCA_BOOT) ? boot_idx_r[5:0] : addr;
    case (st_r)
      UCCA_BOOT: begin
        if (boot_idx_r == 7'd48) st_nxt = UCCA_IDLE;
      end
      UCCA_IDLE: begin
        if (rx_vld_r) begin
          if (rx_sh_r[7:6] == OP_NV_RD && rx_sh_r[5:0] == RESET_ADDR)
            st_nxt = UCCA_SEND_RST;
          else if (rx_sh_r[7:6] == OP_RAM_RD || rx_sh_r[7:6] == OP_NV_RD)
            st_nxt = UCCA_RDMEM;
          else if (rx_sh_r[7:6] == OP_NV_WR && rx_sh_r[5:0] > NV_LAST)
            st_nxt = UCCA_IDLE;
          else
            st_nxt = UCCA_SEND_ECHO;
        end
      end
      UCCA_RDMEM: st_nxt = UCCA_SEND_RD;
      UCCA_SEND_RD: begin
        tx_go = 1'b1;
        tx_byte = (op == OP_RAM_RD) ? ram_rd : nv_rd;
        if (!tx_busy) st_nxt = UCCA_TX_WAIT;
      end
      UCCA_SEND_ECHO: begin
        tx_go = 1'b1;
        tx_byte = cmd_r;
        if (!tx_busy) st_nxt = UCCA_TX_WAIT;
      end
      UCCA_WAIT_DATA: begin
        if (rx_vld_r) st_nxt = UCCA_STORE;
      end
      UCCA_STORE: begin
        ram_we = (op == OP_RAM_WR);
        nv_we = (op == OP_NV_WR);
        st_nxt = UCCA_SEND_ACK1;
      end
      UCCA_SEND_ACK1, UCCA_SEND_ACK2: begin
        tx_go = 1'b1;
        if (!tx_busy) st_nxt = UCCA_TX_WAIT;
      end
      UCCA_SEND_RST: begin
        tx_go = 1'b1;
        if (!tx_busy) st_nxt = UCCA_TX_WAIT;
      end
      UCCA_TX_WAIT: begin
        if (!tx_busy) st_nxt = ret_r;
      end
      default: st_nxt = UCCA_IDLE;
    endcase
  end

  // state, command and return registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= UCCA_BOOT;
      ret_r <= UCCA_IDLE;
      cmd_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_r == UCCA_IDLE && rx_vld_r) cmd_r <= rx_sh_r;
      case (st_r)
        UCCA_SEND_ECHO: ret_r <= UCCA_WAIT_DATA;
        UCCA_SEND_ACK1: ret_r <= UCCA_SEND_ACK2;
        UCCA_SEND_RST: ret_r <= UCCA_BOOT;
        UCCA_SEND_RD, UCCA_SEND_ACK2: ret_r <= UCCA_IDLE;
        default: ret_r <= ret_r;
      endcase
    end
  end

  // soft reset: pulse after BCh leaves, then reboot
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= (st_r == UCCA_TX_WAIT) && !tx_busy &&
        (ret_r == UCCA_BOOT);
    end
  end

  // boot walk over the store and checksum
  always_ff @(posedge clk) begin
    if (rst || soft_reset_pulse) begin
      boot_idx_r <= '0;
      boot_sum_r <= '0;
      csum_fail_r <= 1'b0;
    end else if (st_r == UCCA_BOOT) begin
      if (boot_idx_r < 7'd48) boot_idx_r <= boot_idx_r + 7'd1;
      if (boot_rd_ok_r) boot_sum_r <= boot_sum_r + nv_rd;
    end else if (boot_idx_r == 7'd48) begin
      boot_idx_r <= 7'd49;
      csum_fail_r <= (boot_sum_r != CSUM_GOOD);
    end
  end

  // supervision from the active config
  wire [7:0] mode = cfg_r[MODE_ADDR];
  wire [3:0] sel = cfg_r[ALM_CTRL][7:4];
  logic [7:0] sig8; // upper 8 of selected source
  logic sel_ok, steer_ok; // legal source codes
  always_comb begin
    sig8 = src_s2_r[2][9:2];
    sel_ok = 1'b1;
    steer_ok = 1'b1;
    case (sel)
      SRC_TEMP: sig8 = src_s2_r[0][9:2];
      SRC_INSTR: sig8 = src_s2_r[1][9:2];
      SRC_GAIN: sig8 = src_s2_r[2][9:2];
      SRC_VOUT: sig8 = src_s2_r[3][9:2];
      SRC_AUXA: begin
        sig8 = src_s2_r[4][9:2];
        steer_ok = 1'b0;
      end
      SRC_AUXB: begin
        sig8 = src_s2_r[5][9:2];
        steer_ok = 1'b0;
      end
      default: begin
        sel_ok = 1'b0;
        steer_ok = 1'b0;
      end
    endcase
  end

  wire steer_en = mode[MB_STEER] && steer_ok;
  wire alarm_en = mode[MB_ALARM] && !mode[MB_STEER] && sel_ok;
  wire dual_dig = mode[MB_DIG] && mode[MB_VOUT] && mode[MB_IOUT];

  // override output register
  always_ff @(posedge clk) begin
    if (rst || st_r == UCCA_BOOT) begin
      digital_output_override <= 1'b0;
      override_value <= '0;
    end else if (mode[MB_CSUM] && csum_fail_r) begin
      digital_output_override <= 1'b1;
      override_value <= {cfg_r[FAULT_HI][1:0], cfg_r[FAULT_LO]};
    end else if (alarm_en && sig8 < cfg_r[ALM_LO_TRIG]) begin
      digital_output_override <= 1'b1;
      override_value <= {cfg_r[ALM_LO_OUT], 2'h0};
    end else if (alarm_en && sig8 > cfg_r[ALM_HI_TRIG]) begin
      digital_output_override <= 1'b1;
      override_value <= {cfg_r[ALM_HI_OUT], 2'h0};
    end else begin
      digital_output_override <= 1'b0;
      override_value <= '0;
    end
  end

  // steering code on aux pins, inputs when off
  always_ff @(posedge clk) begin
    if (rst || st_r == UCCA_BOOT) begin
      aux_pin_a_o <= 1'b0;
      aux_pin_b_o <= 1'b0;
      aux_pin_a_oe <= 1'b0;
      aux_pin_b_oe <= 1'b0;
    end else begin
      aux_pin_a_oe <= steer_en;
      aux_pin_b_oe <= steer_en;
      if (sig8 >= cfg_r[STEER_L3]) begin
        {aux_pin_b_o, aux_pin_a_o} <= 2'h3;
      end else if (sig8 >= cfg_r[STEER_L2]) begin
        {aux_pin_b_o, aux_pin_a_o} <= 2'h2;
      end else if (sig8 >= cfg_r[STEER_L1]) begin
        {aux_pin_b_o, aux_pin_a_o} <= 2'h1;
      end else begin
        {aux_pin_b_o, aux_pin_a_o} <= 2'h0;
      end
    end
  end

  // mode byte and fixed current value
  always_ff @(posedge clk) begin
    if (rst || st_r == UCCA_BOOT) begin
      operating_mode_byte <= '0;
      current_fixed <= 1'b0;
      current_fixed_value <= '0;
    end else begin
      operating_mode_byte <= mode;
      current_fixed <= dual_dig;
      current_fixed_value <= {cfg_r[FIXCUR_HI][1:0], cfg_r[FIXCUR_LO]};
    end
  end
endmodule : ucca_top
`default_nettype wire

// ---- tb/ucca_top_properties.sv ----
// port-level properties of the command interpreter top
// assumes one clock, synchronous active-high reset
`default_nettype none
module ucca_top_checker
  import ucca_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched outputs
  input wire logic tx_pin,
  input wire logic aux_pin_a_oe,
  input wire logic aux_pin_b_oe,
  input wire logic digital_output_override,
  input wire logic current_fixed,
  input wire logic [7:0] operating_mode_byte,
  input wire logic soft_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // line idle high once reset lifts
  property p_tx_idle; $fell(rst) |-> tx_pin; endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("tx not idle after reset");
  // a start bit is never a glitch
  property p_start; $fell(tx_pin) |-> !tx_pin [*8]; endproperty
  a_start: assert property (p_start)
    else $error("start bit too short");
  // pins driven only with steering on
  property p_oe_mode;
    aux_pin_a_oe |-> operating_mode_byte[MB_STEER];
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("aux pin driven without steering");
  // both pins form one code
  property p_oe_pair; aux_pin_a_oe == aux_pin_b_oe; endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("aux enables differ");
  // override needs alarm without steering, or checksum test
  property p_ovr;
    digital_output_override |-> operating_mode_byte[MB_CSUM] ||
      (operating_mode_byte[MB_ALARM] && !operating_mode_byte[MB_STEER]);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("override without cause");
  // fixed current follows the three mode bits
  property p_curfix;
    $stable(operating_mode_byte) [*3] |-> current_fixed ==
      (operating_mode_byte[MB_DIG] && operating_mode_byte[MB_VOUT] &&
      operating_mode_byte[MB_IOUT]);
  endproperty
  a_curfix: assert property (p_curfix)
    else $error("fixed current mismatch");
  // reset pulse lasts one cycle
  property p_pulse; soft_reset_pulse |=> !soft_reset_pulse; endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse too long");
  // pulse only after the receipt byte's stop bit
  property p_pulse_stop;
    soft_reset_pulse |-> $past(tx_pin) && $past(tx_pin, 8);
  endproperty
  a_pulse_stop: assert property (p_pulse_stop)
    else $error("reset pulse during a frame");
endmodule : ucca_top_checker
bind ucca_top ucca_top_checker ucca_top_checker_inst (.clk(clk), .rst(rst),
  .tx_pin(tx_pin), .aux_pin_a_oe(aux_pin_a_oe), .aux_pin_b_oe(aux_pin_b_oe),
  .digital_output_override(digital_output_override),
  .current_fixed(current_fixed), .operating_mode_byte(operating_mode_byte),
  .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

// ---- tb/ucca_host.sv ----
// host side of the serial link, 8N1 lsb first
// assumes the bench clock and the package bit time
`default_nettype none
module ucca_host (
  // clock
  input wire logic clk,
  // link seen from the host
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ucca_pkg::*;
  initial line_out = 1'b1; // idle high
  // one bit of idle first, so data never overlaps an echo
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= fr[i];
      repeat ((i == 9) ? BIT_CYC / 4 : BIT_CYC - 1) @(posedge clk);
    end
  endtask : send_byte
  // wait a bounded time for a start bit, sample bit centres
  task automatic recv_byte(input int lim, output logic [7:0] b,
                           output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line_in !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n < lim) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      ok = (line_in === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk);
      ok = ok && (line_in === 1'b1);
    end
  endtask : recv_byte
endmodule : ucca_host
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the serial command interpreter
// assumes the host model and the bound port checker
`default_nettype none
`define CHK(nm, g, e) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ucca_pkg::*;
  localparam int LIMIT = 75000; // cycle ceiling, run needs about 50k
  // alarm bytes: low trigger, low out, high trigger, high out, control
  localparam logic [7:0] ALM_BYTES [0:4] = '{8'h40, 8'h11, 8'hc0, 8'hee,
    {SRC_TEMP, 4'h0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_pin, tx_pin, a_o, a_oe, b_o, b_oe, ovr, cfix, srp;
  logic [9:0] lvl = 10'h000; // moving signal levels
  logic lvl_run = 1'b1; // sweep the levels
  logic [9:0] lvl_hold = 10'h000; // level held when not sweeping
  logic [9:0] ovr_val, cfix_val;
  logic [7:0] mode;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk; // 125 MHz
  always @(posedge clk) lvl <= lvl_run ? lvl + 10'h007 : lvl_hold;
  ucca_top ucca_top_inst (.clk(clk), .rst(rst), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .temp_amp_output(lvl),
    .instr_amp_output(lvl + 10'h011), .gain_stage_output(lvl + 10'h022),
    .voltage_output_mode(lvl + 10'h033), .aux_pin_a_level(~lvl),
    .aux_pin_b_level(lvl ^ 10'h155), .aux_pin_a_o(a_o),
    .aux_pin_a_oe(a_oe), .aux_pin_b_o(b_o), .aux_pin_b_oe(b_oe),
    .digital_output_override(ovr), .override_value(ovr_val),
    .current_fixed_value(cfix_val), .current_fixed(cfix),
    .operating_mode_byte(mode), .soft_reset_pulse(srp));
  ucca_host ucca_host_inst (.clk(clk), .line_in(tx_pin), .line_out(rx_pin));
  // verdict and end of run
  task automatic print_verdict;
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // one answer byte from the device
  task automatic expect_rx(input string what, input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    ucca_host_inst.recv_byte(3 * BIT_CYC, b, ok);
    `CHK({what, " frame"}, ok, 1'b1)
    `CHK(what, b, exp)
  endtask : expect_rx
  // command, echo, data, two acknowledges
  task automatic write_cycle(input logic [7:0] cmd, input logic [7:0] d);
    ucca_host_inst.send_byte(cmd);
    expect_rx("echo", cmd);
    ucca_host_inst.send_byte(d);
    expect_rx("ack1", ACK_BYTE);
    expect_rx("ack2", ACK_BYTE);
  endtask : write_cycle
  // single read command answered unprompted
  task automatic read_cycle(input logic [7:0] cmd, input logic [7:0] exp);
    ucca_host_inst.send_byte(cmd);
    expect_rx("read", exp);
  endtask : read_cycle
  // reset request: receipt byte, one pulse, reload of the store
  task automatic reboot(input logic [7:0] exp_mode);
    logic seen;
    read_cycle({OP_NV_RD, RESET_ADDR}, ACK_BYTE);
    seen = 1'b0;
    repeat (2 * BIT_CYC) begin
      @(posedge clk);
      #1;
      seen = seen | (srp === 1'b1);
    end
    `CHK("soft reset", seen, 1'b1)
    repeat (60) @(posedge clk);
    #1;
    `CHK("mode loaded", mode, exp_mode)
  endtask : reboot
  // hold the sources still at one level and let it settle
  task automatic set_level(input logic [9:0] v);
    @(posedge clk);
    lvl_run <= 1'b0;
    lvl_hold <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask : set_level
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    logic seen;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    write_cycle({OP_NV_WR, MODE_ADDR}, 8'h45);
    #1;
    `CHK("mode deferred", mode === 8'h45, 1'b0)
    read_cycle({OP_NV_RD, MODE_ADDR}, 8'h45);
    write_cycle({OP_RAM_WR, 6'h3f}, 8'h5a);
    read_cycle({OP_RAM_RD, 6'h3f}, 8'h5a);
    // store writes past the top are refused silently
    for (int i = 0; i < 2; i++) begin
      ucca_host_inst.send_byte({OP_NV_WR, i ? RESET_ADDR : 6'h30});
      seen = 1'b0;
      repeat (2 * BIT_CYC) begin
        @(posedge clk);
        seen = seen | (tx_pin !== 1'b1);
      end
      `CHK("refused", seen, 1'b0)
    end
    // alarm bytes cleared while the alarm is unused
    for (int i = 0; i < 5; i++) begin
      write_cycle({OP_NV_WR, ALM_LO_TRIG + 6'(i)}, 8'h00);
    end
    write_cycle({OP_NV_WR, FIXCUR_HI}, 8'h02);
    write_cycle({OP_NV_WR, FIXCUR_LO}, 8'h5a);
    reboot(8'h45);
    `CHK("fixed current", cfix, 1'b1)
    `CHK("fixed value", cfix_val, 10'h25a)
    `CHK("override", ovr, 1'b0)
    `CHK("aux a enable", a_oe, 1'b0)
    `CHK("aux b enable", b_oe, 1'b0)
    // alarm on the temperature source
    for (int i = 0; i < 5; i++) begin
      write_cycle({OP_NV_WR, ALM_LO_TRIG + 6'(i)}, ALM_BYTES[i]);
    end
    write_cycle({OP_NV_WR, MODE_ADDR}, 8'h65);
    reboot(8'h65);
    set_level(10'h040);
    `CHK("alarm low", ovr, 1'b1)
    `CHK("alarm low value", ovr_val, {ALM_BYTES[1], 2'h0})
    set_level(10'h3fc);
    `CHK("alarm high", ovr, 1'b1)
    `CHK("alarm high value", ovr_val, {ALM_BYTES[3], 2'h0})
    set_level(10'h200);
    `CHK("alarm quiet", ovr, 1'b0)
    `CHK("alarm quiet value", ovr_val, 10'h000)
    // steering takes the pins and silences the alarm
    write_cycle({OP_NV_WR, MODE_ADDR}, 8'h75);
    reboot(8'h75);
    set_level(10'h040);
    `CHK("steer silences alarm", ovr, 1'b0)
    `CHK("aux a steer enable", a_oe, 1'b1)
    `CHK("aux b steer enable", b_oe, 1'b1)
    `CHK("steer code 0", {b_o, a_o}, 2'h0)
    set_level(10'h200);
    `CHK("steer code 1", {b_o, a_o}, 2'h1)
    set_level(10'h3fc);
    `CHK("steer code 3", {b_o, a_o}, 2'h3)
    print_verdict();
  end
endmodule : tb
`default_nettype wire
